// File: rscl_pkg.sv
package rscl_pkg;

  // Strap vector layout
  localparam int STRAP_W = 13;
  localparam int S_HOST_WIDTH = 0;
  localparam int S_RSV7 = 1;
  localparam int S_RSV8 = 2;
  localparam int S_RSV9 = 3;
  localparam int S_CELL = 4;
  localparam int S_AUTOINIT = 5;
  localparam int S_CLKB = 6;
  localparam int S_CLKA = 8;
  localparam int S_BOOT = 10;
  localparam int S_ENDIAN = 12;

  // Pull defaults: little endian, ROM boot, pin clocks, two pulled-up reserved lines
  localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 13'h180C;

  // Boot source codes
  localparam logic [1:0] BOOT_NONE = 2'h0;
  localparam logic [1:0] BOOT_HOST = 2'h1;
  localparam logic [1:0] BOOT_ROM = 2'h2;
  localparam logic [1:0] BOOT_RSV = 2'h3;

  // Memory interface clock source codes
  localparam logic [1:0] CLK_PIN = 2'h0;
  localparam logic [1:0] CLK_DIV4 = 2'h1;
  localparam logic [1:0] CLK_DIV6 = 2'h2;
  localparam logic [1:0] CLK_RSV = 2'h3;

  // Register byte offsets
  localparam logic [3:0] REG_STRAP = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PINFUNC = 4'h8;

  // Pin function register: bit 0 is GP8, bits 7:1 are GP15..GP9
  localparam int PINFUNC_W = 8;
  localparam logic [PINFUNC_W-1:0] PINFUNC_RST = 8'h00;

  // Status register bit positions
  localparam int ST_LITTLE = 0;
  localparam int ST_BOOT_HOST = 1;
  localparam int ST_BOOT_ROM = 2;
  localparam int ST_PCI_OWN = 3;
  localparam int ST_EE_LOAD = 4;
  localparam int ST_HOST32 = 5;
  localparam int ST_SP2_EN = 6;
  localparam int ST_CELL_OWN = 7;
  localparam int ST_CONFLICT = 8;
  localparam int ST_W = 9;

  typedef enum logic [1:0] {
    RSCL_SAMPLE = 2'b01,
    RSCL_HOLD = 2'b10
  } rscl_phase_e;

endpackage

// File: rscl_strap_board.sv
`timescale 1ns/1ps
`default_nettype none

module rscl_strap_board (
  input wire logic clk_i,
  input wire logic [12:0] cfg_i,
  input wire logic float_i,
  input wire logic pci_i,
  output logic [20:1] ext_mem_b_address_lines_o,
  output logic host_data5_o,
  output logic [12:0] strap_undriven_o
);
  logic tick = 1'b0;
  logic [12:0] v;
  always @(posedge clk_i) begin
    tick <= ~tick;
  end
  // Floating lines show a changing level
  always_comb begin
    v = cfg_i;
    v[5] = cfg_i[5] & pci_i;
    v[3:2] = 2'b11;
    v[1] = tick;
    if (float_i) begin
      v[12:4] = {9{tick}};
      v[0] = tick;
    end
  end
  assign strap_undriven_o = float_i ? 13'h1FF3 : 13'h0002;
  assign ext_mem_b_address_lines_o = {v[12:5], tick, v[4], ~tick, v[3:1], {6{tick}}};
  assign host_data5_o = v[0];
endmodule

`default_nettype wire

// File: rscl_strap_latch.sv
//
// Behaviour
// - Sample straps in reset, hold after
// - Endian strap: low big, high little
// - Boot code: none, host, ROM, reserved
// - Interface A clock: pin, /4, /6
// - Interface B clock: pin, /4, /6
// - Auto-init low: PCI uses built-in defaults
// - Auto-init high loads EEPROM if PCI, no SP2
// - Width strap low: 16-bit, upper lines off
// - Width strap high: all 32 lines used
// - Strap-muxed pins owned by one, fixed
// - Software-muxed pins changeable after reset; GP15..GP9 held off while PCI owns
`timescale 1ns/1ps
`default_nettype none

module rscl_strap_latch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [20:1] ext_mem_b_address_lines_i,
  input wire logic host_data5_i,
  input wire logic [12:0] strap_undriven_i,
  input wire logic pci_select_i,
  input wire logic serial_port2_select_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic endian_little_o,
  output logic [1:0] boot_mode_o,
  output logic [1:0] ext_mem_a_clock_select_o,
  output logic [1:0] ext_mem_b_clock_select_o,
  output logic pci_eeprom_load_o,
  output logic pci_default_config_o,
  output logic host_port_32bit_mode_o,
  output logic host_data_upper_oe_o,
  output logic pci_owner_o,
  output logic host_port_owner_o,
  output logic cell_port_owner_o,
  output logic serial_port1_owner_o,
  output logic serial_port2_enable_o,
  output logic [7:0] gpio_pin_enable_o
);

  typedef struct packed {
    rscl_pkg::rscl_phase_e phase;
    logic [rscl_pkg::STRAP_W-1:0] straps;
    logic pci_sel;
    logic sp2_at_reset;
    logic [rscl_pkg::PINFUNC_W-1:0] pinfunc;
    logic ack;
    logic [31:0] dat;
    logic endian;
    logic [1:0] boot;
    logic [1:0] clka;
    logic [1:0] clkb;
    logic ee_load;
    logic def_cfg;
    logic host32;
    logic upper_oe;
    logic pci_own;
    logic host_own;
    logic cell_own;
    logic sp1_own;
    logic sp2_en;
    logic [7:0] gpio_en;
  } rscl_state_s;

  rscl_state_s s_reg;
  rscl_state_s s_next;

  logic [27:0] pins_sync;
  logic [12:0] raw_straps;
  logic [12:0] undriven_sync;
  logic [12:0] resolved;
  logic pci_sync;
  logic sp2_sync;
  logic wr_pinfunc;

  // Pin order follows the strap vector layout
  assign raw_straps = {ext_mem_b_address_lines_i[20:13], ext_mem_b_address_lines_i[11],
                       ext_mem_b_address_lines_i[9:7], host_data5_i};

  rscl_sync #(.W(28)) u_sync (
    .clk_i(clk_i),
    .async_i({strap_undriven_i, pci_select_i, serial_port2_select_i, raw_straps}),
    .sync_o(pins_sync)
  );

  assign undriven_sync = pins_sync[27:15];
  assign pci_sync = pins_sync[14];
  assign sp2_sync = pins_sync[13];

  // Floating strap falls back to its pull default
  assign resolved = (pins_sync[12:0] & ~undriven_sync) |
                    (rscl_pkg::STRAP_DEFAULT & undriven_sync);

  // Register read mux
  function automatic logic [31:0] rd_data(input rscl_state_s st, input logic [3:0] adr);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (adr)
      rscl_pkg::REG_STRAP: r = {19'h0, st.straps};
      rscl_pkg::REG_STATUS: begin
        r[rscl_pkg::ST_LITTLE] = st.endian;
        r[rscl_pkg::ST_BOOT_HOST] = (st.boot == rscl_pkg::BOOT_HOST);
        r[rscl_pkg::ST_BOOT_ROM] = (st.boot == rscl_pkg::BOOT_ROM);
        r[rscl_pkg::ST_PCI_OWN] = st.pci_own;
        r[rscl_pkg::ST_EE_LOAD] = st.ee_load;
        r[rscl_pkg::ST_HOST32] = st.host32;
        r[rscl_pkg::ST_SP2_EN] = st.sp2_en;
        r[rscl_pkg::ST_CELL_OWN] = st.cell_own;
        r[rscl_pkg::ST_CONFLICT] = st.straps[rscl_pkg::S_AUTOINIT] & ~st.pci_sel;
      end
      rscl_pkg::REG_PINFUNC: r = {24'h0, st.pinfunc};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign wr_pinfunc = wb_cyc_i & wb_stb_i & wb_we_i & ~s_reg.ack &
                      (wb_adr_i == rscl_pkg::REG_PINFUNC) & wb_sel_i[0];

  always_comb begin
    s_next = s_reg;
    // Classic single-cycle answer, unmapped reads give zero
    s_next.ack = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    s_next.dat = (wb_cyc_i & wb_stb_i & ~s_reg.ack) ? rd_data(s_reg, wb_adr_i) : 32'h0000_0000;
    if (wr_pinfunc) begin
      s_next.pinfunc = wb_dat_i[7:0];
    end
    unique case (s_reg.phase)
      rscl_pkg::RSCL_SAMPLE: begin
        s_next.phase = rscl_pkg::RSCL_HOLD;
      end
      rscl_pkg::RSCL_HOLD: begin
        s_next.phase = rscl_pkg::RSCL_HOLD;
      end
      default: begin
        s_next.phase = rscl_pkg::RSCL_HOLD;
      end
    endcase
    if (rst_i) begin
      // Straps tracked only while reset stands
      s_next.phase = rscl_pkg::RSCL_SAMPLE;
      s_next.straps = resolved;
      s_next.pci_sel = pci_sync;
      s_next.sp2_at_reset = sp2_sync;
      s_next.pinfunc = rscl_pkg::PINFUNC_RST;
      s_next.ack = 1'b0;
      s_next.dat = 32'h0000_0000;
    end
    // Decoded settings follow the held straps
    s_next.endian = s_next.straps[rscl_pkg::S_ENDIAN];
    s_next.boot = s_next.straps[rscl_pkg::S_BOOT +: 2];
    s_next.clka = s_next.straps[rscl_pkg::S_CLKA +: 2];
    s_next.clkb = s_next.straps[rscl_pkg::S_CLKB +: 2];
    s_next.ee_load = s_next.straps[rscl_pkg::S_AUTOINIT] & s_next.pci_sel &
                     ~s_next.sp2_at_reset;
    s_next.def_cfg = ~s_next.ee_load;
    s_next.host32 = s_next.straps[rscl_pkg::S_HOST_WIDTH];
    s_next.upper_oe = s_next.straps[rscl_pkg::S_HOST_WIDTH];
    s_next.pci_own = s_next.pci_sel;
    s_next.host_own = ~s_next.pci_sel;
    s_next.cell_own = s_next.straps[rscl_pkg::S_CELL];
    s_next.sp1_own = ~s_next.straps[rscl_pkg::S_CELL];
    // Serial port 2 select may move at run time
    s_next.sp2_en = ~(s_next.pci_sel & ~sp2_sync);
    s_next.gpio_en = {s_next.pinfunc[7:1] & {7{~s_next.pci_sel}},
                      s_next.pinfunc[0]};
  end

  always_ff @(posedge clk_i) begin
    s_reg <= s_next;
  end

  assign wb_dat_o = s_reg.dat;
  assign wb_ack_o = s_reg.ack;
  assign endian_little_o = s_reg.endian;
  assign boot_mode_o = s_reg.boot;
  assign ext_mem_a_clock_select_o = s_reg.clka;
  assign ext_mem_b_clock_select_o = s_reg.clkb;
  assign pci_eeprom_load_o = s_reg.ee_load;
  assign pci_default_config_o = s_reg.def_cfg;
  assign host_port_32bit_mode_o = s_reg.host32;
  assign host_data_upper_oe_o = s_reg.upper_oe;
  assign pci_owner_o = s_reg.pci_own;
  assign host_port_owner_o = s_reg.host_own;
  assign cell_port_owner_o = s_reg.cell_own;
  assign serial_port1_owner_o = s_reg.sp1_own;
  assign serial_port2_enable_o = s_reg.sp2_en;
  assign gpio_pin_enable_o = s_reg.gpio_en;

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  straps_held_a: assert property (
    $past(!rst_i) |-> $stable(s_reg.straps) && $stable(s_reg.pci_sel))
    else $error("straps changed after reset");

  endian_decode_a: assert property (
    $past(!rst_i) |-> endian_little_o == s_reg.straps[rscl_pkg::S_ENDIAN])
    else $error("endian output wrong");

  boot_decode_a: assert property (
    boot_mode_o == s_reg.straps[rscl_pkg::S_BOOT +: 2] && $stable(boot_mode_o))
    else $error("boot mode wrong");

  clock_sel_a: assert property (
    ext_mem_a_clock_select_o == s_reg.straps[rscl_pkg::S_CLKA +: 2])
    else $error("interface A clock select wrong");

  clock_selb_a: assert property (
    ext_mem_b_clock_select_o == s_reg.straps[rscl_pkg::S_CLKB +: 2])
    else $error("interface B clock select wrong");

  eeprom_gate_a: assert property (
    pci_eeprom_load_o |-> pci_owner_o && s_reg.straps[rscl_pkg::S_AUTOINIT] &&
    !s_reg.sp2_at_reset && !pci_default_config_o)
    else $error("eeprom load without its conditions");

  default_cfg_a: assert property (
    !s_reg.straps[rscl_pkg::S_AUTOINIT] |-> pci_default_config_o && !pci_eeprom_load_o)
    else $error("defaults not used");

  host_width_a: assert property (
    host_data_upper_oe_o == host_port_32bit_mode_o &&
    host_port_32bit_mode_o == s_reg.straps[rscl_pkg::S_HOST_WIDTH])
    else $error("host width wrong");

  owner_once_a: assert property (
    (pci_owner_o ^ host_port_owner_o) && (cell_port_owner_o ^ serial_port1_owner_o) &&
    $stable(pci_owner_o))
    else $error("pin owner not unique");

  pin_func_a: assert property (
    wr_pinfunc |=> gpio_pin_enable_o[0] == $past(wb_dat_i[0]) && wb_ack_o)
    else $error("pin function write lost");

  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held");

  host_wide_a: assert property (
    host_port_32bit_mode_o |-> host_data_upper_oe_o && s_reg.straps[rscl_pkg::S_HOST_WIDTH])
    else $error("wide host port not using upper lines");

  strap_stable_a: assert property (
    $past(!rst_i) |-> $stable(endian_little_o) && $stable(ext_mem_a_clock_select_o) &&
    $stable(ext_mem_b_clock_select_o) && $stable(host_port_32bit_mode_o))
    else $error("decoded setting moved after reset");

  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");

  ack_source_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");

  dat_idle_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");

  strap_read_a: assert property (
    wb_ack_o && $past(!wb_we_i) && $past(wb_adr_i) == rscl_pkg::REG_STRAP |->
    wb_dat_o == {19'h0_0000, s_reg.straps})
    else $error("strap register read wrong");

  pinfunc_read_a: assert property (
    wb_ack_o && $past(!wb_we_i) && $past(wb_adr_i) == rscl_pkg::REG_PINFUNC |->
    wb_dat_o == {24'h00_0000, s_reg.pinfunc})
    else $error("pin function read wrong");

  sp2_enable_a: assert property (
    serial_port2_enable_o == !(s_reg.pci_sel && !$past(sp2_sync)))
    else $error("serial port 2 enable wrong");

  gpio_mask_a: assert property (
    pci_owner_o |-> gpio_pin_enable_o[7:1] == 7'h00)
    else $error("shared pins given to gpio");

  pinfunc_held_a: assert property (
    !$past(wr_pinfunc) |-> $stable(s_reg.pinfunc))
    else $error("pin function changed without write");

  ee_strap_a: assert property (
    s_reg.straps[rscl_pkg::S_AUTOINIT] && s_reg.pci_sel && !s_reg.sp2_at_reset |->
    pci_eeprom_load_o)
    else $error("eeprom load missing");

  eeprom_cov: cover property (pci_eeprom_load_o);
  host_boot_cov: cover property (boot_mode_o == rscl_pkg::BOOT_HOST);
  pin_write_cov: cover property (wr_pinfunc);
  host32_cov: cover property (host_port_32bit_mode_o && pci_owner_o);
  sp2_live_cov: cover property (serial_port2_enable_o && pci_owner_o);

endmodule

`default_nettype wire

// File: rscl_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rscl_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // Two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk_i) begin
    meta_reg <= async_i;
    sync_reg <= meta_reg;
  end

  assign sync_o = sync_reg;

endmodule

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [12:0] cfg = 13'h0000;
  logic flt = 1'b1;
  logic pci_select_i = 1'b0;
  logic serial_port2_select_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, q;
  logic wb_ack_o, endian_little_o, pci_eeprom_load_o, pci_default_config_o;
  logic host_port_32bit_mode_o, host_data_upper_oe_o, pci_owner_o, host_port_owner_o;
  logic cell_port_owner_o, serial_port1_owner_o, serial_port2_enable_o, host_data5_i;
  logic [1:0] boot_mode_o, ext_mem_a_clock_select_o, ext_mem_b_clock_select_o;
  logic [7:0] gpio_pin_enable_o;
  logic [20:1] ext_mem_b_address_lines_i;
  logic [12:0] strap_undriven_i;
  logic [14:0] outs;
  int bad_count = 0;
  int num_checks = 0;

  always #5 clk_i = ~clk_i;

  rscl_strap_board i_board (.clk_i, .cfg_i(cfg), .float_i(flt), .pci_i(pci_select_i),
    .ext_mem_b_address_lines_o(ext_mem_b_address_lines_i), .host_data5_o(host_data5_i),
    .strap_undriven_o(strap_undriven_i));

  rscl_strap_latch i_dut (.clk_i, .rst_i, .ext_mem_b_address_lines_i, .host_data5_i,
    .strap_undriven_i, .pci_select_i, .serial_port2_select_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .endian_little_o,
    .boot_mode_o, .ext_mem_a_clock_select_o, .ext_mem_b_clock_select_o, .pci_eeprom_load_o,
    .pci_default_config_o, .host_port_32bit_mode_o, .host_data_upper_oe_o, .pci_owner_o,
    .host_port_owner_o, .cell_port_owner_o, .serial_port1_owner_o, .serial_port2_enable_o,
    .gpio_pin_enable_o);

  assign outs = {endian_little_o, boot_mode_o, ext_mem_a_clock_select_o,
    ext_mem_b_clock_select_o, pci_eeprom_load_o, pci_default_config_o, host_port_32bit_mode_o,
    host_data_upper_oe_o, pci_owner_o, host_port_owner_o, cell_port_owner_o,
    serial_port1_owner_o};

  function automatic logic [14:0] dec(input logic [12:0] s, input logic p, input logic s2);
    logic ld;
    ld = s[5] & p & ~s2;
    dec = {s[12:6], ld, ~ld, s[0], s[0], p, ~p, s[4], ~s[4]};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic settle();
    repeat (5) @(negedge clk_i);
  endtask

  task automatic wb(input logic we, input logic [3:0] a, input logic [3:0] sl,
    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= sl;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      bad_count++;
      summarize();
    end
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic boot(input logic [12:0] c, input logic f, input logic p, input logic s);
    @(posedge clk_i);
    rst_i <= 1'b1;
    cfg <= c;
    flt <= f;
    pci_select_i <= p;
    serial_port2_select_i <= s;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
  endtask

  initial begin
    logic [1:0] k;
    logic [12:0] c, s;
    logic p, s2;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      c = {k[0], k, k, ~k, 1'b1, k[1], 3'b000, k[0]};
      p = (k != 2'h0);
      s2 = k[0];
      s = {c[12:6], c[5] & p, c[4], 3'b110, c[0]};
      boot(c, 1'b0, p, s2);
      chk("decode", outs, dec(s, p, s2));
      chk("sp2en", serial_port2_enable_o, !(p && !s2));
      wb(1'b0, rscl_pkg::REG_STRAP, 4'hF, 32'h0, q);
      chk("strap", q, {19'h0, s});
      cfg <= ~c;
      serial_port2_select_i <= ~s2;
      settle();
      chk("held", outs, dec(s, p, s2));
      chk("sp2live", serial_port2_enable_o, !(p && s2));
    end
    wb(1'b1, rscl_pkg::REG_PINFUNC, 4'h1, 32'hFF, q);
    settle();
    chk("gpio", gpio_pin_enable_o, 8'h01);
    wb(1'b1, rscl_pkg::REG_PINFUNC, 4'hE, 32'h0, q);
    wb(1'b1, rscl_pkg::REG_STRAP, 4'hF, 32'h0, q);
    wb(1'b0, rscl_pkg::REG_PINFUNC, 4'hF, 32'h0, q);
    chk("pinfunc", q, 32'hFF);
    wb(1'b0, rscl_pkg::REG_STRAP, 4'hF, 32'h0, q);
    chk("strap ro", q, {19'h0, s});
    wb(1'b0, 4'hC, 4'hF, 32'h0, q);
    chk("unmapped", q, 32'h0);
    boot(13'h0000, 1'b1, 1'b0, 1'b0);
    chk("default", outs, dec(13'h180C, 1'b0, 1'b0));
    chk("gpio rst", gpio_pin_enable_o, 8'h00);
    wb(1'b0, rscl_pkg::REG_STATUS, 4'hF, 32'h0, q);
    chk("status", q, 32'h45);
    wb(1'b1, rscl_pkg::REG_PINFUNC, 4'h1, 32'hA5, q);
    settle();
    chk("gpio sw", gpio_pin_enable_o, 8'hA5);
    summarize();
  end
endmodule

`default_nettype wire
